// ==== common/dqv_pkg.sv ====
package dqv_pkg;

  // register block offsets, in bytes
  localparam logic [7:0] OFS_FW_ID = 8'h00;
  localparam logic [7:0] OFS_GLOBAL = 8'h04;
  localparam logic [7:0] OFS_ACTION = 8'h0A;
  localparam logic [7:0] OFS_EPB = 8'h24;
  localparam logic [7:0] OFS_VEC_12 = 8'h28;
  localparam logic [7:0] OFS_VEC_34 = 8'h2C;
  localparam logic [7:0] OFS_VEC_56 = 8'h30;
  localparam logic [7:0] OFS_VEC_78 = 8'h34;
  localparam logic [7:0] OFS_BULK = 8'h3C;
  localparam logic [7:0] OFS_IDHI_LO = 8'h40;
  localparam logic [7:0] OFS_IDHI_HI = 8'h44;

  // out packet header
  localparam int HDR_WRITE_BIT = 2;
  localparam int HDR_VCG_BIT = 3;
  localparam logic [1:0] HDR_RB_CODE = 2'h1;

  // reset values
  localparam logic [11:0] EPB_RST = 12'h001;
  localparam logic [31:0] IDHI_RST = 32'hFFFF_FFFF;

  // fields
  localparam logic [3:0] BUFOPT_EVENTS = 4'h9;
  localparam int GLB_MASK_ENA_BIT = 15;
  localparam int ACT_TRIG_BIT = 1;
  localparam int FWID_MASK_LSB = 24;
  localparam int VEC_HALF = 16;
  localparam int VEC_LVL_LSB = 8;
  localparam int VEC_STK_LSB = 12;
  localparam int BULK_TMO_LSB = 8;
  localparam logic [7:0] IDLO_OFF = 8'h00;

  // usb packet lengths in bytes
  localparam logic [9:0] PKT_LEN_HS = 10'h200;
  localparam logic [9:0] PKT_LEN_FS = 10'h040;

  // watchdog timing
  localparam int WDOG_BASE_S = 1;
  localparam longint CLK_FREQ_HZ = 250_000_000;
  localparam int WDOG_SEC_CYC = int'(CLK_FREQ_HZ * WDOG_BASE_S);

endpackage : dqv_pkg

// ==== rtl/dqv_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module dqv_ctrl
  import dqv_pkg::*;
#(
  parameter int CYC_PER_SEC = WDOG_SEC_CYC,
  parameter logic [31:0] FW_ID = 32'h0000_0A5A  // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // out packet words from the usb fifo, pipe 0
  input wire logic [15:0] out_word,
  input wire logic out_valid,
  input wire logic out_last,
  output logic out_ready_q,
  // in packet words to the common output buffer, pipe 2
  output logic [15:0] in_word_q,
  output logic in_valid_q,
  input wire logic in_ready,
  // command generator hand-off
  output logic vcg_req_q,
  output logic [15:0] vcg_word_q,
  output logic vcg_valid_q,
  // usb side
  input wire logic high_speed_pin,
  output logic [9:0] pkt_len_q,
  output logic usb_trigger_q,
  output logic pkt_end_q,
  // data buffer
  input wire logic event_end,
  input wire logic buf_full,
  output logic buf_xfer_q,
  // interrupts
  input wire logic [6:0] irq_req_pin,
  output logic [6:0] irq_pending_q,
  input wire logic iack_done,
  input wire logic [2:0] iack_level,
  input wire logic [15:0] iack_id,
  output logic stack_start_q,
  output logic [2:0] stack_id_q
);

  if (CYC_PER_SEC < 2) begin : g_bad_cyc
    $error("CYC_PER_SEC too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic vec_hit(input logic [15:0] v, input logic [7:0] hi,
                                   input logic [2:0] lvl, input logic [15:0] id);
    vec_hit = (v[7:0] != IDLO_OFF) && (v[VEC_LVL_LSB +: 3] == lvl)
              && ({hi, v[7:0]} == id);
  endfunction : vec_hit

  typedef enum logic [2:0] {
    S_HDR, S_SUB, S_WLO, S_WHI, S_RLO, S_RHI, S_DRAIN
  } dqv_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] global_q;
  logic [11:0] epb_q;
  logic [31:0] vec_q [0:3];
  logic [31:0] bulk_q;
  logic [31:0] idhi_q [0:1];
  logic [6:0] mask_q;

  // pin synchronisers
  logic [6:0] irq_s1_q, irq_s2_q;
  logic hs_s1_q, hs_s2_q;

  always_ff @(posedge clk) begin
    irq_s1_q <= irq_req_pin;
    irq_s2_q <= irq_s1_q;
    hs_s1_q <= high_speed_pin;
    hs_s2_q <= hs_s1_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // out packet parser
  dqv_state_t state_q, state_d;
  logic [15:0] hdr_q;
  logic [7:0] sub_q;
  logic [15:0] wlo_q;
  logic [15:0] rsp_hi_q;

  wire take = out_valid && out_ready_q;
  wire hdr_vcg = out_word[HDR_VCG_BIT];
  wire hdr_rb = !hdr_vcg && (out_word[1:0] == HDR_RB_CODE) && (out_word[5:4] == 2'h0);
  wire is_write = hdr_q[HDR_WRITE_BIT];
  wire in_acc = in_valid_q && in_ready;
  wire sub_action = (sub_q == OFS_ACTION);
  wire wr_full = (state_q == S_WHI) && take;
  wire wr_action = (state_q == S_WLO) && take && sub_action;
  wire [31:0] wr_data = {out_word, wlo_q};
  wire trig_bit = out_word[ACT_TRIG_BIT];
  wire mask_ena = global_q[GLB_MASK_ENA_BIT];

  // read mux, addressed by the incoming sub-address word
  wire [7:0] rd_addr = out_word[7:0];
  logic [31:0] rd_data;
  always_comb begin
    case (rd_addr)
      OFS_FW_ID: begin
        rd_data = FW_ID;
        if (mask_ena) rd_data[FWID_MASK_LSB +: 7] = mask_q;
      end
      OFS_GLOBAL: rd_data = {16'h0000, global_q};
      OFS_EPB: rd_data = {20'h00000, epb_q};
      OFS_VEC_12: rd_data = vec_q[0];
      OFS_VEC_34: rd_data = vec_q[1];
      OFS_VEC_56: rd_data = vec_q[2];
      OFS_VEC_78: rd_data = vec_q[3];
      OFS_BULK: rd_data = bulk_q;
      OFS_IDHI_LO: rd_data = idhi_q[0];
      OFS_IDHI_HI: rd_data = idhi_q[1];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_HDR: if (take) begin
        if (hdr_vcg) state_d = out_last ? S_HDR : S_DRAIN;
        else if (hdr_rb && !out_last) state_d = S_SUB;
        else if (!out_last) state_d = S_DRAIN;
      end
      S_SUB: if (take) begin
        if (!is_write) state_d = S_RLO;
        else state_d = out_last ? S_HDR : S_WLO;
      end
      S_WLO: if (take) begin
        if (sub_action) state_d = out_last ? S_HDR : S_DRAIN;
        else state_d = out_last ? S_HDR : S_WHI;
      end
      S_WHI: if (take) state_d = out_last ? S_HDR : S_DRAIN;
      S_RLO: if (in_acc) state_d = S_RHI;
      S_RHI: if (in_acc) state_d = S_HDR;
      S_DRAIN: if (take && out_last) state_d = S_HDR;
      default: state_d = S_HDR;
    endcase
  end

  wire resp_d = (state_d == S_RLO) || (state_d == S_RHI);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_HDR;
      out_ready_q <= 1'b0;
      hdr_q <= 16'h0000;
      sub_q <= 8'h00;
      wlo_q <= 16'h0000;
      rsp_hi_q <= 16'h0000;
      in_word_q <= 16'h0000;
      in_valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_ready_q <= !resp_d;
      if (take && state_q == S_HDR) hdr_q <= out_word;
      if (take && state_q == S_SUB) sub_q <= out_word[7:0];
      if (take && state_q == S_WLO) wlo_q <= out_word;
      if (take && state_q == S_SUB && !is_write) begin
        in_word_q <= rd_data[15:0];
        rsp_hi_q <= rd_data[31:16];
        in_valid_q <= 1'b1;
      end else if (in_acc && state_q == S_RLO) begin
        in_word_q <= rsp_hi_q;
      end else if (in_acc && state_q == S_RHI) begin
        in_valid_q <= 1'b0;
      end
    end
  end

  // command generator words pass through as an implicit request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vcg_req_q <= 1'b0;
      vcg_word_q <= 16'h0000;
      vcg_valid_q <= 1'b0;
    end else begin
      vcg_req_q <= take && state_q == S_HDR && hdr_vcg;
      vcg_valid_q <= take && state_q == S_DRAIN && hdr_q[HDR_VCG_BIT];
      if (take) vcg_word_q <= out_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_q <= 16'h0000;
      epb_q <= EPB_RST;
      vec_q <= '{default: 32'h0000_0000};
      bulk_q <= 32'h0000_0000;
      idhi_q <= '{default: IDHI_RST};
      mask_q <= 7'h00;
      usb_trigger_q <= 1'b0;
    end else begin
      usb_trigger_q <= wr_action && trig_bit;
      if (wr_action && trig_bit && mask_ena) mask_q <= global_q[6:0];
      if (wr_full) begin
        case (sub_q)
          OFS_GLOBAL: global_q <= wr_data[15:0];
          OFS_EPB: epb_q <= wr_data[11:0];
          OFS_VEC_12: vec_q[0] <= wr_data;
          OFS_VEC_34: vec_q[1] <= wr_data;
          OFS_VEC_56: vec_q[2] <= wr_data;
          OFS_VEC_78: vec_q[3] <= wr_data;
          OFS_BULK: bulk_q <= wr_data;
          OFS_IDHI_LO: idhi_q[0] <= wr_data;
          OFS_IDHI_HI: idhi_q[1] <= wr_data;
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt vectors, all compared at once
  logic [7:0] hit;
  for (genvar k = 0; k < 8; k++) begin : g_vec
    assign hit[k] = vec_hit(vec_q[k/2][VEC_HALF*(k%2) +: 16],
                            idhi_q[k/4][8*(k%4) +: 8], iack_level, iack_id);
  end

  logic [2:0] hit_stack;
  always_comb begin
    hit_stack = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (hit[k]) hit_stack = vec_q[k/2][VEC_HALF*(k%2) + VEC_STK_LSB +: 3];
    end
  end

  wire lvl_ok = (iack_level != 3'h0) && !mask_q[iack_level - 3'h1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stack_start_q <= 1'b0;
      stack_id_q <= 3'h0;
      irq_pending_q <= 7'h00;
    end else begin
      irq_pending_q <= irq_s2_q & ~mask_q;
      stack_start_q <= iack_done && lvl_ok && (hit != 8'h00);
      if (iack_done && lvl_ok && (hit != 8'h00)) stack_id_q <= hit_stack;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events per buffer and buffer hand-off
  logic [11:0] evt_cnt_q;
  wire opt_events = (global_q[3:0] == BUFOPT_EVENTS);
  wire [11:0] evt_next = evt_cnt_q + 12'h001;
  wire evt_full = (evt_next >= epb_q);
  wire xfer_d = opt_events ? (event_end && evt_full) : buf_full;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_cnt_q <= 12'h000;
      buf_xfer_q <= 1'b0;
    end else begin
      buf_xfer_q <= xfer_d;
      if (!opt_events) evt_cnt_q <= 12'h000;
      else if (event_end) evt_cnt_q <= evt_full ? 12'h000 : evt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bulk bundling and packet-end watchdog
  logic [7:0] bcnt_q;
  logic [31:0] tick_q;
  logic [3:0] sec_q;
  wire [7:0] nbuf = bulk_q[7:0];
  wire [3:0] tmo_sec = {1'b0, bulk_q[BULK_TMO_LSB +: 3]} + 4'h1;
  wire [7:0] bcnt_next = bcnt_q + 8'h01;
  wire sec_tick = (tick_q == 32'(CYC_PER_SEC - 1));
  wire wd_fire = (bcnt_q != 8'h00) && sec_tick && (sec_q + 4'h1 >= tmo_sec);
  wire bundle_done = buf_xfer_q && (bcnt_next >= nbuf);
  wire pend_d = (nbuf == 8'h00) ? (buf_xfer_q || event_end)
                                : (bundle_done || wd_fire);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bcnt_q <= 8'h00;
      tick_q <= 32'h0000_0000;
      sec_q <= 4'h0;
      pkt_end_q <= 1'b0;
    end else begin
      pkt_end_q <= pend_d;
      if (nbuf == 8'h00 || bundle_done || wd_fire) begin
        bcnt_q <= 8'h00;
        tick_q <= 32'h0000_0000;
        sec_q <= 4'h0;
      end else begin
        if (buf_xfer_q) bcnt_q <= bcnt_next;
        if (bcnt_q != 8'h00) begin
          tick_q <= sec_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
          if (sec_tick) sec_q <= sec_q + 4'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // usb packet length from link speed
  always_ff @(posedge clk) begin
    if (sys_rst) pkt_len_q <= PKT_LEN_FS;
    else pkt_len_q <= hs_s2_q ? PKT_LEN_HS : PKT_LEN_FS;
  end

endmodule : dqv_ctrl

`default_nettype wire

// ==== tb/dqv_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module dqv_ctrl_checker
  import dqv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // out and in packets
  input wire logic out_valid,
  input wire logic out_ready_q,
  input wire logic [15:0] in_word_q,
  input wire logic in_valid_q,
  input wire logic in_ready,
  input wire logic vcg_req_q,
  // usb side
  input wire logic high_speed_pin,
  input wire logic [9:0] pkt_len_q,
  input wire logic usb_trigger_q,
  // buffers and interrupts
  input wire logic event_end,
  input wire logic buf_full,
  input wire logic buf_xfer_q,
  input wire logic iack_done,
  input wire logic [2:0] iack_level,
  input wire logic stack_start_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_stack_cause: assert property (stack_start_q |-> $past(iack_done))
    else $error("stack start without acknowledge");
  a_stack_lvl0: assert property (iack_done && iack_level == 3'h0 |=> !stack_start_q)
    else $error("stack start on level zero");
  a_xfer_cause: assert property (buf_xfer_q |-> $past(event_end) || $past(buf_full))
    else $error("buffer hand-off without cause");
  a_trig_single: assert property (usb_trigger_q |=> !usb_trigger_q)
    else $error("trigger longer than one cycle");
  a_len_high: assert property (high_speed_pin [*5] |=> pkt_len_q == PKT_LEN_HS)
    else $error("wrong high speed packet length");
  a_len_full: assert property ((!high_speed_pin) [*5] |=> pkt_len_q == PKT_LEN_FS)
    else $error("wrong full speed packet length");
  a_in_hold: assert property (in_valid_q && !in_ready |=> in_valid_q && $stable(in_word_q))
    else $error("answer word dropped while stalled");
  a_ready_wait: assert property (in_valid_q |-> !out_ready_q)
    else $error("new word taken while answer pending");
  a_vcg_take: assert property (vcg_req_q |-> $past(out_valid && out_ready_q))
    else $error("command request without taken word");
endmodule : dqv_ctrl_checker

bind dqv_ctrl dqv_ctrl_checker dqv_ctrl_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .out_valid(out_valid), .out_ready_q(out_ready_q), .in_word_q(in_word_q),
  .in_valid_q(in_valid_q), .in_ready(in_ready), .vcg_req_q(vcg_req_q),
  .high_speed_pin(high_speed_pin), .pkt_len_q(pkt_len_q), .usb_trigger_q(usb_trigger_q),
  .event_end(event_end), .buf_full(buf_full), .buf_xfer_q(buf_xfer_q),
  .iack_done(iack_done), .iack_level(iack_level), .stack_start_q(stack_start_q));

`default_nettype wire

// ==== tb/dqv_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module dqv_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // in packets read back
  input wire logic [15:0] in_word_q,
  input wire logic in_valid_q,
  output logic in_ready,
  output logic [31:0] rx_q,
  output int rx_cnt
);
  logic [1:0] stall_q;
  // ready two cycles of four: prompt and slow reads
  assign in_ready = stall_q[1];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stall_q <= 2'h0;
      rx_cnt <= 0;
    end else begin
      stall_q <= stall_q + 2'h1;
      if (in_valid_q && in_ready) begin
        rx_q <= {in_word_q, rx_q[31:16]};
        rx_cnt <= rx_cnt + 1;
      end
    end
  end
endmodule : dqv_host_model

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb
  import dqv_pkg::*;
;
  logic clk, sys_rst, out_valid, out_last, out_ready_q, in_valid_q, in_ready;
  logic vcg_req_q, vcg_valid_q, high_speed_pin, usb_trigger_q, pkt_end_q;
  logic event_end, buf_full, buf_xfer_q, iack_done, stack_start_q;
  logic [15:0] out_word, in_word_q, vcg_word_q, iack_id;
  logic [9:0] pkt_len_q;
  logic [6:0] irq_req_pin, irq_pending_q;
  logic [2:0] iack_level, stack_id_q;
  logic [31:0] rx, d;
  int bad_count, checks, rx_cnt, e;
  int cyc = 0, n_xfer = 0, n_end = 0, n_trg = 0, n_stk = 0;
  int n_vreq = 0, n_vwd = 0;

  dqv_ctrl #(.CYC_PER_SEC(20)) dqv_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .out_word(out_word), .out_valid(out_valid), .out_last(out_last),
    .out_ready_q(out_ready_q), .in_word_q(in_word_q), .in_valid_q(in_valid_q),
    .in_ready(in_ready), .vcg_req_q(vcg_req_q), .vcg_word_q(vcg_word_q),
    .vcg_valid_q(vcg_valid_q), .high_speed_pin(high_speed_pin), .pkt_len_q(pkt_len_q),
    .usb_trigger_q(usb_trigger_q), .pkt_end_q(pkt_end_q), .event_end(event_end),
    .buf_full(buf_full), .buf_xfer_q(buf_xfer_q), .irq_req_pin(irq_req_pin),
    .irq_pending_q(irq_pending_q), .iack_done(iack_done), .iack_level(iack_level),
    .iack_id(iack_id), .stack_start_q(stack_start_q), .stack_id_q(stack_id_q));
  dqv_host_model dqv_host_model_inst (.clk(clk), .sys_rst(sys_rst), .in_word_q(in_word_q),
    .in_valid_q(in_valid_q), .in_ready(in_ready), .rx_q(rx), .rx_cnt(rx_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pulse counters and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_xfer <= n_xfer + buf_xfer_q;
    n_end <= n_end + pkt_end_q;
    n_trg <= n_trg + usb_trigger_q;
    n_stk <= n_stk + stack_start_q;
    n_vreq <= n_vreq + vcg_req_q;
    n_vwd <= n_vwd + vcg_valid_q;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sw(input logic [15:0] w, input logic l);
    out_word <= w;
    out_valid <= 1'b1;
    out_last <= l;
    do @(posedge clk); while (out_ready_q !== 1'b1);
    if (l) out_valid <= 1'b0;
  endtask : sw
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    sw(16'h0005, 1'b0);
    sw({8'h00, a}, 1'b0);
    sw(v[15:0], 1'b0);
    sw(v[31:16], 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = rx_cnt;
    sw(16'h0001, 1'b0);
    sw({8'h00, a}, 1'b1);
    for (int k = 0; k < 50 && rx_cnt < n + 2; k++) @(posedge clk);
    v = rx;
  endtask : rd
  task automatic pulse(input logic ev, input logic bf);
    @(posedge clk);
    event_end <= ev;
    buf_full <= bf;
    @(posedge clk);
    event_end <= 1'b0;
    buf_full <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic iq(input logic [2:0] l, input logic [15:0] i, input int x, input logic [2:0] s);
    int n;
    n = n_stk;
    @(posedge clk);
    iack_done <= 1'b1;
    iack_level <= l;
    iack_id <= i;
    @(posedge clk);
    iack_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(n_stk, n + x);
    if (x != 0) chk({29'h0, stack_id_q}, {29'h0, s});
  endtask : iq

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1; out_word = 16'h0; out_valid = 1'b0; out_last = 1'b0;
    high_speed_pin = 1'b1; event_end = 1'b0; buf_full = 1'b0; irq_req_pin = 7'h00;
    iack_done = 1'b0; iack_level = 3'h0; iack_id = 16'h0; bad_count = 0; checks = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_EPB, d); chk(d, {20'h0, EPB_RST});
    rd(OFS_IDHI_LO, d); chk(d, IDHI_RST);
    rd(8'h50, d); chk(d, 32'h0);
    chk({22'h0, pkt_len_q}, {22'h0, PKT_LEN_HS});
    wr(OFS_GLOBAL, {28'h0, BUFOPT_EVENTS});
    wr(OFS_EPB, 32'h3);
    repeat (2) pulse(1'b1, 1'b0);
    chk(n_xfer, 0);
    pulse(1'b1, 1'b0); chk(n_xfer, 1);
    wr(OFS_GLOBAL, 32'h0);
    e = n_end;
    pulse(1'b1, 1'b0); chk(n_xfer, 1);
    pulse(1'b0, 1'b1); chk(n_xfer, 2);
    chk(n_end, e + 2);
    wr(OFS_BULK, 32'h102);
    e = n_end;
    pulse(1'b0, 1'b1); chk(n_end, e);
    pulse(1'b0, 1'b1); chk(n_end, e + 1);
    pulse(1'b0, 1'b1);
    repeat (30) @(posedge clk);
    chk(n_end, e + 1);
    repeat (15) @(posedge clk);
    chk(n_end, e + 2);
    wr(OFS_BULK, 32'h0);
    wr(OFS_VEC_12, 32'h5322_2100);
    wr(OFS_VEC_34, 32'h0000_5433);
    wr(OFS_VEC_78, 32'h0000_7211);
    wr(OFS_IDHI_HI, 32'hFF12_FFFF);
    iq(3'h3, 16'hFF22, 1, 3'h5);
    iq(3'h1, 16'hFF00, 0, 3'h0);
    iq(3'h4, 16'hFF33, 1, 3'h5);
    iq(3'h2, 16'h1211, 1, 3'h7);
    iq(3'h2, 16'hFF11, 0, 3'h0);
    iq(3'h0, 16'hFF22, 0, 3'h0);
    wr(OFS_GLOBAL, 32'h0000_8002);
    e = n_trg;
    sw(16'h0005, 1'b0);
    sw({8'h00, OFS_ACTION}, 1'b0);
    sw(16'h0002, 1'b1);
    repeat (3) @(posedge clk);
    chk(n_trg, e + 1);
    rd(OFS_FW_ID, d); chk({25'h0, d[30:24]}, 32'h2);
    iq(3'h2, 16'h1211, 0, 3'h0);
    irq_req_pin <= 7'h03;
    repeat (6) @(posedge clk);
    chk({25'h0, irq_pending_q}, 32'h1);
    wr(OFS_GLOBAL, 32'h0);
    iq(3'h2, 16'h1211, 0, 3'h0);
    sw(16'h0006, 1'b0);
    sw(16'h0002, 1'b1);
    sw(16'h000C, 1'b0);
    sw(16'h1234, 1'b0);
    sw(16'hABCD, 1'b1);
    high_speed_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(n_vreq, 1);
    chk(n_vwd, 2);
    chk({16'h0, vcg_word_q}, 32'h0000_ABCD);
    chk({22'h0, pkt_len_q}, {22'h0, PKT_LEN_FS});
    results();
  end
endmodule : tb

`default_nettype wire
